// *** shared/ubm_pkg.sv ***
// constants, register map and state types of the serial buffer, modem and irq block
// Function
// - modem status bits show inverted low-true pins
// - any modem pin change sets modem-change bit
// - modem change interrupts only with both enables
// - clear-to-send false blocks new character start
// - receiver handles 5 to 8 bits, right-justified
// - first received data bit lands in bit 0
// - unused upper received bits read as zero
// - bit sampling phase aligned to start bit
// - finished character loads holding, sets ready
// - full receive fifo plus new character sets overrun
// - transmit byte waits until serializer empty
// - transmitter uses receiver length, ignores upper bits
// - transmit bit 0 goes out first
// - empty pin tracks holding; complete needs both
// - modem status read clears change detector only
// - status interrupts fire on rising edges only
// - status read clears bits, pins unchanged
// - reset sets complete bit and its edge
// - status set deferred to read trailing edge
// - recurring set bit during read gets cleared
// - global enable false holds interrupt low
// - complete interrupts; ready and empty never do
package ubm_pkg;

  // ---------------------------------------------------------------
  // register select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_DATA  = 2'h0;
  localparam logic [1:0] SEL_LINE  = 2'h1;
  localparam logic [1:0] SEL_MODEM = 2'h2;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ST_DR   = 0;
  localparam int ST_TRANSMIT_HOLDING_EMPTY = 1;
  localparam int ST_TC   = 2;
  localparam int ST_OVR  = 3;
  localparam int ST_FRM  = 4;
  localparam int ST_MS   = 5;
  localparam int ST_W    = 6;
  localparam int LC_LEN  = 0;
  localparam int LC_STOP = 2;
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_MODEM_IRQ_ENABLE = 2;
  localparam int MC_GLOBAL_IRQ_ENABLE = 3;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [5:0] ST_RESET   = 6'h06;
  localparam logic [5:0] EDGE_RESET = 6'h04;
  localparam logic [5:0] IRQ_MASK   = 6'h1c;
  localparam logic [7:0] LC_RESET   = 8'h03;
  localparam logic [7:0] MC_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // timing in 16x ticks
  // ---------------------------------------------------------------
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID  = 4'h7;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubm_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubm_tx_e;

endpackage : ubm_pkg

// *** core/ubm_core.sv ***
// receive/transmit buffering, modem sensing and interrupt logic with its fifo
`timescale 1ns/1ns

module ubm_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ubm_fifo

module ubm_core #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // processor bus
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] data_in,
  output logic [7:0]      data_out,
  output logic            data_oe,
  // 16x bit clock enable
  input  wire logic       baud_tick16,
  // serial and modem lines
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  output logic            rts_n,
  output logic            dtr_n,
  // request pins
  output logic            data_ready_flag,
  output logic            transmit_holding_empty,
  output logic            interrupt_output
);
  // ---------------------------------------------------------------
  // bus strobes
  // ---------------------------------------------------------------
  logic       rd_act;
  logic       rd_d;
  logic       wr_d;
  logic [1:0] rd_sel;
  logic       rd_end;
  logic       wr_start;
  logic       usr_end;
  logic       msr_end;
  logic       rhr_end;
  logic       reading;
  logic [7:0] line_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] receive_holding;
  logic [7:0] transmit_holding;
  logic [5:0] uart_status_reg;
  logic [1:0] modem_line_status;

  assign rd_act   = ~cs_n & ~rd_n;
  assign rd_end   = rd_d & ~rd_act;
  assign wr_start = ~cs_n & ~wr_n & ~wr_d;
  assign usr_end  = rd_end && rd_sel == ubm_pkg::SEL_LINE;
  assign msr_end  = rd_end && rd_sel == ubm_pkg::SEL_MODEM;
  assign rhr_end  = rd_end && rd_sel == ubm_pkg::SEL_DATA;
  assign reading  = rd_act && (sel == ubm_pkg::SEL_LINE || sel == ubm_pkg::SEL_MODEM);

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_d   <= 1'b0;
      wr_d   <= 1'b0;
      rd_sel <= ubm_pkg::SEL_DATA;
    end else begin
      rd_d   <= rd_act;
      wr_d   <= ~cs_n & ~wr_n;
      rd_sel <= rd_act ? sel : rd_sel;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      line_control_reg  <= ubm_pkg::LC_RESET;
      modem_control_reg <= ubm_pkg::MC_RESET;
    end else if (wr_start && sel == ubm_pkg::SEL_LINE) begin
      line_control_reg  <= data_in;
    end else if (wr_start && sel == ubm_pkg::SEL_MODEM) begin
      modem_control_reg <= data_in;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= rd_act;
      unique case (sel)
        ubm_pkg::SEL_DATA:  data_out <= receive_holding;
        ubm_pkg::SEL_LINE:  data_out <= {2'h0, uart_status_reg};
        ubm_pkg::SEL_MODEM: data_out <= {6'h00, modem_line_status};
        default:            data_out <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // modem lines
  // ---------------------------------------------------------------
  logic ms_event;
  logic ms_detect;
  assign ms_event = modem_line_status != {~dsr_n, ~cts_n};

  always_ff @(posedge clock) begin
    if (rst) begin
      modem_line_status <= 2'h0;
      ms_detect         <= 1'b0;
      rts_n             <= 1'b1;
      dtr_n             <= 1'b1;
    end else begin
      modem_line_status <= {~dsr_n, ~cts_n};
      ms_detect         <= ms_event | (ms_detect & ~msr_end);
      rts_n             <= ~modem_control_reg[ubm_pkg::MC_RTS];
      dtr_n             <= ~modem_control_reg[ubm_pkg::MC_DTR];
    end
  end

  a_ms_change: assert property (@(posedge clock) disable iff (rst)
    {dsr_n, cts_n} != $past({dsr_n, cts_n}) |=> ms_detect)
    else $error("modem pin change not detected");

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  ubm_pkg::ubm_rx_e rx_state;
  logic [3:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic       rx_done;
  logic       rx_ready;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       rh_full;
  logic [2:0] last_bit;
  assign last_bit = 3'h4 + {1'b0, line_control_reg[ubm_pkg::LC_LEN +: 2]};
  assign rx_done  = rx_state == ubm_pkg::RX_STOP && baud_tick16 && rx_cnt == ubm_pkg::TICK_LAST;

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_state <= ubm_pkg::RX_IDLE;
      rx_cnt   <= 4'h0;
      rx_bit   <= 3'h0;
      rx_sh    <= 8'h00;
    end else if (baud_tick16) begin
      rx_cnt <= rx_cnt + 4'h1;
      unique case (rx_state)
        ubm_pkg::RX_IDLE: begin
          rx_cnt <= 4'h0;
          if (!serial_in_pin) begin
            rx_state <= ubm_pkg::RX_START;
          end
        end
        ubm_pkg::RX_START: begin
          // phase set at start bit centre
          if (rx_cnt == ubm_pkg::TICK_MID) begin
            rx_cnt   <= 4'h0;
            rx_bit   <= 3'h0;
            rx_sh    <= 8'h00;
            rx_state <= serial_in_pin ? ubm_pkg::RX_IDLE : ubm_pkg::RX_DATA;
          end
        end
        ubm_pkg::RX_DATA: begin
          if (rx_cnt == ubm_pkg::TICK_LAST) begin
            rx_sh[rx_bit] <= serial_in_pin;
            rx_bit        <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              rx_state <= ubm_pkg::RX_STOP;
            end
          end
        end
        ubm_pkg::RX_STOP: begin
          if (rx_cnt == ubm_pkg::TICK_LAST) begin
            rx_state <= ubm_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  a_rx_upper_zero: assert property (@(posedge clock) disable iff (rst)
    rx_done && line_control_reg[1:0] == 2'h0 |-> rx_sh[7:5] == 3'h0)
    else $error("unused receive bits not zero");

  ubm_fifo #(.W(8), .D(FIFO_DEPTH)) u_rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (rx_done),
    .in_ready  (rx_ready),
    .in_data   (rx_sh),
    .out_valid (fifo_valid),
    .out_ready (~rh_full),
    .out_data  (fifo_data)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      receive_holding <= 8'h00;
      rh_full         <= 1'b0;
    end else if (!rh_full && fifo_valid) begin
      receive_holding <= fifo_data;
      rh_full         <= 1'b1;
    end else if (rhr_end) begin
      rh_full <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  ubm_pkg::ubm_tx_e tx_state;
  logic [3:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic       tx_stop2;
  logic       thr_full;
  logic       tx_load;
  logic       tx_end;
  assign tx_load = tx_state == ubm_pkg::TX_IDLE && thr_full && !cts_n;
  assign tx_end  = tx_state == ubm_pkg::TX_STOP && baud_tick16
                   && tx_cnt == ubm_pkg::TICK_LAST && !tx_stop2;

  always_ff @(posedge clock) begin
    if (rst) begin
      transmit_holding <= 8'h00;
      thr_full         <= 1'b0;
    end else if (wr_start && sel == ubm_pkg::SEL_DATA) begin
      transmit_holding <= data_in;
      thr_full         <= 1'b1;
    end else if (tx_load) begin
      thr_full <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state       <= ubm_pkg::TX_IDLE;
      tx_cnt         <= 4'h0;
      tx_bit         <= 3'h0;
      tx_sh          <= 8'h00;
      tx_stop2       <= 1'b0;
      serial_out_pin <= 1'b1;
    end else if (tx_load) begin
      tx_state <= ubm_pkg::TX_START;
      tx_cnt   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= transmit_holding;
      tx_stop2 <= line_control_reg[ubm_pkg::LC_STOP];
    end else if (baud_tick16 && tx_state != ubm_pkg::TX_IDLE) begin
      tx_cnt <= tx_cnt + 4'h1;
      unique case (tx_state)
        ubm_pkg::TX_START: serial_out_pin <= 1'b0;
        ubm_pkg::TX_DATA:  serial_out_pin <= tx_sh[tx_bit];
        default:           serial_out_pin <= 1'b1;
      endcase
      if (tx_cnt == ubm_pkg::TICK_LAST) begin
        unique case (tx_state)
          ubm_pkg::TX_START: tx_state <= ubm_pkg::TX_DATA;
          ubm_pkg::TX_DATA: begin
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == last_bit) begin
              tx_state <= ubm_pkg::TX_STOP;
            end
          end
          default: begin
            tx_stop2 <= 1'b0;
            if (!tx_stop2) begin
              tx_state <= ubm_pkg::TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  a_cts_hold: assert property (@(posedge clock) disable iff (rst)
    tx_state == ubm_pkg::TX_IDLE && cts_n |=> tx_state == ubm_pkg::TX_IDLE)
    else $error("character started with clear-to-send false");

  // ---------------------------------------------------------------
  // status bits, edge detectors, interrupt
  // ---------------------------------------------------------------
  logic [5:0] ev;
  logic [5:0] pend;
  logic [5:0] st_d;
  logic [5:0] edge_det;
  assign ev[ubm_pkg::ST_DR]   = !rh_full && fifo_valid;
  assign ev[ubm_pkg::ST_TRANSMIT_HOLDING_EMPTY] = tx_load;
  // complete only when both stages empty
  assign ev[ubm_pkg::ST_TC]   = tx_end && !thr_full;
  // overrun when character cannot be kept
  assign ev[ubm_pkg::ST_OVR]  = rx_done && !rx_ready;
  assign ev[ubm_pkg::ST_FRM]  = rx_done && !serial_in_pin;
  assign ev[ubm_pkg::ST_MS]   = ms_event;

  for (genvar i = 0; i < ubm_pkg::ST_W; i++) begin : g_st
    always_ff @(posedge clock) begin
      if (rst) begin
        uart_status_reg[i] <= ubm_pkg::ST_RESET[i];
      end else if (usr_end) begin
        uart_status_reg[i] <= ~uart_status_reg[i] & (pend[i] | ev[i]);
      end else if (msr_end) begin
        uart_status_reg[i] <= uart_status_reg[i] | pend[i] | ev[i];
      end else if (!reading) begin
        uart_status_reg[i] <= uart_status_reg[i] | ev[i];
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        pend[i] <= 1'b0;
      end else if (rd_end) begin
        pend[i] <= 1'b0;
      end else if (reading) begin
        pend[i] <= pend[i] | ev[i];
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        st_d[i]     <= ubm_pkg::ST_RESET[i];
        edge_det[i] <= ubm_pkg::EDGE_RESET[i];
      end else begin
        st_d[i] <= uart_status_reg[i];
        if (uart_status_reg[i] && !st_d[i]) begin
          edge_det[i] <= 1'b1;
        end else if (usr_end) begin
          edge_det[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_ready_flag        <= 1'b0;
      transmit_holding_empty <= 1'b1;
      interrupt_output       <= 1'b0;
    end else begin
      // ready and empty pins follow buffers, not status reads
      data_ready_flag        <= rh_full;
      transmit_holding_empty <= ~thr_full;
      interrupt_output <= modem_control_reg[ubm_pkg::MC_GLOBAL_IRQ_ENABLE]
        & (|(edge_det & ubm_pkg::IRQ_MASK)
           | (modem_control_reg[ubm_pkg::MC_MODEM_IRQ_ENABLE] & ms_detect));
    end
  end

  a_irq_off: assert property (@(posedge clock) disable iff (rst)
    !modem_control_reg[ubm_pkg::MC_GLOBAL_IRQ_ENABLE] |=> !interrupt_output)
    else $error("interrupt raised with global enable off");

  a_tc_reset: assert property (@(posedge clock)
    rst |=> uart_status_reg[ubm_pkg::ST_TC] && edge_det[ubm_pkg::ST_TC])
    else $error("reset did not set complete bit and edge");

  a_usr_clear: assert property (@(posedge clock) disable iff (rst)
    usr_end && uart_status_reg[ubm_pkg::ST_DR] |=> !uart_status_reg[ubm_pkg::ST_DR])
    else $error("status read did not clear ready bit");

  a_read_defer: assert property (@(posedge clock) disable iff (rst)
    reading ##1 reading |-> $stable(uart_status_reg))
    else $error("status bit changed during read");

  a_pin_kept: assert property (@(posedge clock) disable iff (rst)
    usr_end && rh_full ##1 !rhr_end |=> data_ready_flag)
    else $error("ready pin dropped by status read");

  a_tc_both: assert property (@(posedge clock) disable iff (rst)
    ev[ubm_pkg::ST_TC] |=> tx_state == ubm_pkg::TX_IDLE && transmit_holding_empty)
    else $error("complete flagged with data pending");

  a_irq_modem: assert property (@(posedge clock) disable iff (rst)
    ms_detect && !modem_control_reg[ubm_pkg::MC_MODEM_IRQ_ENABLE]
    && !(|(edge_det & ubm_pkg::IRQ_MASK)) |=> !interrupt_output)
    else $error("modem interrupt without modem enable");

endmodule : ubm_core

// *** test/ubm_modem.sv ***
// modem side model: serial frames both ways and handshake lines
`timescale 1ns/1ns

module ubm_modem #(
  parameter int BIT = 32
) (
  // clock
  input  wire logic clock,
  // serial lines
  input  wire logic serial_out_pin,
  output logic      serial_in_pin,
  // handshake lines
  output logic      cts_n,
  output logic      dsr_n
);
  int         rx_len   = 8;
  int         rx_count = 0;
  logic [7:0] rx_data  = 8'h00;

  initial begin
    serial_in_pin = 1'b1;
    cts_n         = 1'b1;
    dsr_n         = 1'b1;
  end

  // ---------------------------------------------------------------
  // frame towards the receiver, lsb first, one stop bit
  // ---------------------------------------------------------------
  task automatic send_char(input logic [7:0] d, input int len);
    serial_in_pin <= 1'b0;
    repeat (BIT) @(posedge clock);
    for (int i = 0; i < len; i++) begin
      serial_in_pin <= d[i];
      repeat (BIT) @(posedge clock);
    end
    serial_in_pin <= 1'b1;
    repeat (BIT) @(posedge clock);
  endtask : send_char

  // ---------------------------------------------------------------
  // capture of transmitted frames, sampled mid bit
  // ---------------------------------------------------------------
  initial begin
    forever begin
      @(negedge serial_out_pin);
      rx_data = 8'h00;
      repeat (BIT + BIT / 2) @(posedge clock);
      for (int i = 0; i < rx_len; i++) begin
        rx_data[i] = serial_out_pin;
        repeat (BIT) @(posedge clock);
      end
      rx_count++;
    end
  end

endmodule : ubm_modem

// *** test/ubm_core_tb.sv ***
// self-checking bench for the buffer, modem and irq block
`timescale 1ns/1ns

module ubm_core_tb;
  localparam int BIT = 32;
  logic       clock;
  logic       rst;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [1:0] sel;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe;
  logic       baud_tick16 = 1'b0;
  logic       serial_in_pin;
  logic       serial_out_pin;
  logic       cts_n;
  logic       dsr_n;
  logic       rts_n;
  logic       dtr_n;
  logic       data_ready_flag;
  logic       transmit_holding_empty;
  logic       interrupt_output;
  logic [7:0] rd;
  int         errors     = 0;
  int         num_checks = 0;

  ubm_core #(.FIFO_DEPTH(4)) i_ubm_core (
    .clock(clock), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .baud_tick16(baud_tick16),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .cts_n(cts_n),
    .dsr_n(dsr_n), .rts_n(rts_n), .dtr_n(dtr_n), .data_ready_flag(data_ready_flag),
    .transmit_holding_empty(transmit_holding_empty), .interrupt_output(interrupt_output)
  );

  ubm_modem #(.BIT(BIT)) i_ubm_modem (
    .clock(clock), .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin),
    .cts_n(cts_n), .dsr_n(dsr_n)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // 16x tick every second clock, so one bit lasts 32 clocks
  always @(posedge clock) baud_tick16 <= rst ? 1'b0 : ~baud_tick16;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [1:0] s, input logic [7:0] d);
    cs_n    <= 1'b0;
    wr_n    <= 1'b0;
    sel     <= s;
    data_in <= d;
    @(posedge clock);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clock);
  endtask : reg_write

  task automatic reg_read(input logic [1:0] s, output logic [7:0] d, input int hold);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    sel  <= s;
    repeat (3 + hold) @(posedge clock);
    d = data_out;
    check(8'(data_oe), 8'h01, "bus driven during read");
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : reg_read

  task automatic wait_cnt(input int n);
    for (int k = 0; k < 40 * BIT && i_ubm_modem.rx_count < n; k++) @(posedge clock);
  endtask : wait_cnt

  task automatic wait_dr();
    for (int k = 0; k < 40 * BIT && data_ready_flag !== 1'b1; k++) @(posedge clock);
  endtask : wait_dr

  task automatic soft_reset(input logic [7:0] lc, input logic [7:0] mc);
    reg_write(ubm_pkg::SEL_LINE, lc);
    reg_write(ubm_pkg::SEL_MODEM, 8'h00);
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    reg_read(ubm_pkg::SEL_MODEM, rd, 0);
    reg_read(ubm_pkg::SEL_DATA, rd, 0);
    reg_write(ubm_pkg::SEL_MODEM, mc);
  endtask : soft_reset

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    reg_write(ubm_pkg::SEL_MODEM, 8'h0b);
    repeat (3) @(posedge clock);
    check(8'(interrupt_output), 8'h01, "irq from reset complete");
    check(8'({rts_n, dtr_n}), 8'h00, "modem control pins low");
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    check(rd, 8'h06, "status after reset");
    repeat (2) @(posedge clock);
    check(8'(interrupt_output), 8'h00, "irq after status read");
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    check(rd, 8'h00, "status cleared by read");
    check(8'(transmit_holding_empty), 8'h01, "empty pin kept");
    reg_write(2'h3, 8'hff);
    reg_read(2'h3, rd, 0);
    check(rd, 8'h00, "unmapped select");
  endtask : t_reset

  task automatic t_modem();
    soft_reset(8'h03, 8'h04);
    i_ubm_modem.cts_n <= 1'b0;
    repeat (4) @(posedge clock);
    check(8'(interrupt_output), 8'h00, "global enable off");
    reg_read(ubm_pkg::SEL_MODEM, rd, 0);
    check(rd & 8'h03, 8'h01, "inverted cts");
    reg_write(ubm_pkg::SEL_MODEM, 8'h0c);
    i_ubm_modem.dsr_n <= 1'b0;
    repeat (4) @(posedge clock);
    check(8'(interrupt_output), 8'h01, "modem irq both enables");
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    check(rd & 8'h20, 8'h20, "modem change bit");
    check(8'(interrupt_output), 8'h01, "detector kept");
    reg_read(ubm_pkg::SEL_MODEM, rd, 0);
    check(rd & 8'h03, 8'h03, "modem bits follow pins");
    repeat (2) @(posedge clock);
    check(8'(interrupt_output), 8'h00, "detector cleared");
    reg_write(ubm_pkg::SEL_MODEM, 8'h08);
    i_ubm_modem.dsr_n <= 1'b1;
    repeat (4) @(posedge clock);
    check(8'(interrupt_output), 8'h00, "modem enable off");
  endtask : t_modem

  task automatic t_rx();
    for (int len = 5; len <= 8; len++) begin
      soft_reset(8'(len - 5), 8'h08);
      i_ubm_modem.send_char(8'hd3, len);
      wait_dr();
      check(8'(data_ready_flag), 8'h01, "ready pin");
      check(8'(interrupt_output), 8'h00, "ready gives no irq");
      reg_read(ubm_pkg::SEL_DATA, rd, 0);
      check(rd, 8'hd3 & 8'((1 << len) - 1), "received word");
    end
  endtask : t_rx

  task automatic t_overrun();
    soft_reset(8'h03, 8'h08);
    for (int i = 0; i < 6; i++) i_ubm_modem.send_char(8'h40 + 8'(i), 8);
    repeat (BIT) @(posedge clock);
    check(8'(interrupt_output), 8'h01, "overrun irq");
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    check(rd & 8'h09, 8'h09, "overrun and ready");
    for (int i = 0; i < 5; i++) begin
      reg_read(ubm_pkg::SEL_DATA, rd, 0);
      check(rd, 8'h40 + 8'(i), "buffered order");
      repeat (2) @(posedge clock);
    end
    check(8'(data_ready_flag), 8'h00, "drained");
  endtask : t_overrun

  task automatic t_read_window();
    soft_reset(8'h03, 8'h00);
    fork
      i_ubm_modem.send_char(8'h5a, 8);
      reg_read(ubm_pkg::SEL_LINE, rd, 12 * BIT);
    join
    check(rd & 8'h01, 8'h00, "ready held during read");
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    check(rd & 8'h01, 8'h01, "ready after trailing edge");
    reg_read(ubm_pkg::SEL_DATA, rd, 0);
    check(rd, 8'h5a, "received word");
    i_ubm_modem.cts_n <= ~i_ubm_modem.cts_n;
    repeat (4) @(posedge clock);
    fork
      begin
        repeat (4) @(posedge clock);
        i_ubm_modem.cts_n <= ~i_ubm_modem.cts_n;
      end
      reg_read(ubm_pkg::SEL_LINE, rd, 8);
    join
    check(rd & 8'h20, 8'h20, "change bit set");
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    check(rd & 8'h20, 8'h00, "recurring bit cleared");
  endtask : t_read_window

  task automatic t_tx();
    int c0;
    soft_reset(8'h03, 8'h08);
    c0 = i_ubm_modem.rx_count;
    reg_write(ubm_pkg::SEL_DATA, 8'ha5);
    reg_write(ubm_pkg::SEL_DATA, 8'h3c);
    @(posedge clock);
    check(8'(transmit_holding_empty), 8'h00, "holding full");
    repeat (3 * BIT) @(posedge clock);
    i_ubm_modem.cts_n <= 1'b1;
    wait_cnt(c0 + 1);
    check(i_ubm_modem.rx_data, 8'ha5, "first frame lsb first");
    repeat (15 * BIT) @(posedge clock);
    check(8'(i_ubm_modem.rx_count - c0), 8'h01, "cts blocks start");
    check(8'(transmit_holding_empty), 8'h00, "byte kept");
    check(8'(interrupt_output), 8'h00, "empty gives no irq");
    i_ubm_modem.cts_n <= 1'b0;
    wait_cnt(c0 + 2);
    check(i_ubm_modem.rx_data, 8'h3c, "held byte sent");
    repeat (2 * BIT) @(posedge clock);
    check(8'(interrupt_output), 8'h01, "complete irq");
    reg_read(ubm_pkg::SEL_LINE, rd, 0);
    check(rd & 8'h06, 8'h06, "empty and complete");
    reg_write(ubm_pkg::SEL_LINE, 8'h04);
    reg_write(ubm_pkg::SEL_DATA, 8'h21);
    wait_cnt(c0 + 3);
    check(i_ubm_modem.rx_data, 8'he1, "short word, upper ignored");
  endtask : t_tx

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #4_000_000;
    errors++;
    give_verdict();
  end

  initial begin
    rst     = 1'b1;
    cs_n    = 1'b1;
    rd_n    = 1'b1;
    wr_n    = 1'b1;
    sel     = 2'h0;
    data_in = 8'h00;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_modem();
    t_rx();
    t_overrun();
    t_read_window();
    t_tx();
    give_verdict();
  end

endmodule : ubm_core_tb
